// File: design/pdc_pkg.sv
// package for the pre-driver control and status register block
package pdc_pkg;
	// ********************************************************
	// register offsets
	// ********************************************************
	localparam logic [3:0] OFS_CMD        = 4'h0;
	localparam logic [3:0] OFS_HEAT_DUTY  = 4'h9;
	localparam logic [3:0] OFS_SPKA_DUTY  = 4'hA;
	localparam logic [3:0] OFS_SPKB_DUTY  = 4'hB;
	localparam logic [3:0] OFS_HEAT_FAULT = 4'h7;
	localparam logic [3:0] OFS_SPKA_FAULT = 4'h8;
	localparam logic [3:0] OFS_SPKB_FAULT = 4'h9;
	localparam logic [3:0] OFS_STATE_IND  = 4'hE;
	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int         BIT_SUMMARY = 7;
	localparam int         BIT_OPEN    = 3;
	localparam int         BIT_OVER    = 2;
	localparam int         DRV_HEAT    = 0;
	localparam int         DRV_SPKB    = 1;
	localparam int         DRV_SPKA    = 2;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [6:0] DUTY_FULL   = 7'h64;
	localparam logic [6:0] PHASE_LAST  = 7'h63;
	// ********************************************************
	// timing
	// ********************************************************
	localparam int CLK_HZ         = 50_000_000;
	localparam int SLOW_PERIOD_US = 10_000;
	localparam int FAST_PERIOD_US = 1_000;
	localparam int STEPS          = 100;
	localparam int SLOW_STEP_CYC  =
		CLK_HZ / 1_000_000 * SLOW_PERIOD_US / STEPS;
	localparam int FAST_STEP_CYC  =
		CLK_HZ / 1_000_000 * FAST_PERIOD_US / STEPS;
	// ********************************************************
	// modes and carriers
	// ********************************************************
	typedef enum logic [1:0] {
		PWM_NONE = 2'b00,
		PWM_SLOW = 2'b01,
		PWM_FAST = 2'b10,
		PWM_EXT  = 2'b11
	} pdc_pwm_mode_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       stat_space;
		logic [3:0] addr;
		logic [7:0] wdata;
	} pdc_req_t;
	typedef struct packed {
		logic [7:0]      cmd;
		logic [2:0][6:0] duty;
		logic [2:0][7:0] status;
		logic [7:0]      ind;
		logic            any_fault;
		logic [12:0]     slow_cnt;
		logic [8:0]      fast_cnt;
		logic            slow_tick;
		logic            fast_tick;
		logic [2:0][6:0] phase;
		logic [2:0]      pin_prev;
		logic [2:0]      drive;
		logic [7:0]      rdata;
		logic            rvalid;
	} pdc_state_t;
endpackage

// File: design/pdc_regs.sv
// pre-driver control and status registers with duty generators
// ************************************************************
// ************************************************************
`timescale 1ns/1ns
`default_nettype none
module pdc_regs #(
	parameter int SLOW_STEP = pdc_pkg::SLOW_STEP_CYC
) (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire pdc_pkg::pdc_req_t   req,
	input  wire logic [2:0]          drv_pin,
	input  wire logic [2:0]          and_select,
	input  wire logic [2:0]          open_detect_sink_enable,
	input  wire logic [2:0][1:0]     pwm_source_mode,
	input  wire logic [2:0]          open_load_raw,
	input  wire logic [2:0]          overcurrent_raw,
	output logic [7:0]               rdata,
	output logic                     rvalid,
	output logic [2:0]               drive_out,
	output logic [4:0]               low_side_out,
	output logic                     any_fault
);
	import pdc_pkg::*;

	localparam logic [12:0] SLOW_WRAP = 13'(SLOW_STEP - 1);
	localparam logic [8:0]  FAST_WRAP = 9'(FAST_STEP_CYC - 1);

	pdc_state_t st_ff;
	pdc_state_t nxt_st;

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic [6:0] duty_clip(input logic [6:0] d);
		duty_clip = (d > DUTY_FULL) ? DUTY_FULL : d;
	endfunction

	function automatic int duty_slot(input logic [3:0] a);
		case (a)
			OFS_HEAT_DUTY: duty_slot = DRV_HEAT;
			OFS_SPKA_DUTY: duty_slot = DRV_SPKA;
			OFS_SPKB_DUTY: duty_slot = DRV_SPKB;
			default:       duty_slot = -1;
		endcase
	endfunction

	function automatic int stat_slot(input logic [3:0] a);
		case (a)
			OFS_HEAT_FAULT: stat_slot = DRV_HEAT;
			OFS_SPKA_FAULT: stat_slot = DRV_SPKA;
			OFS_SPKB_FAULT: stat_slot = DRV_SPKB;
			default:        stat_slot = -1;
		endcase
	endfunction

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		logic       tick;
		logic       pwm_on;
		logic       want;
		logic [7:0] sbyte;
		int         ds;
		int         ss;
		tick   = 1'b0;
		pwm_on = 1'b0;
		want   = 1'b0;
		sbyte  = RST_BYTE;
		ds     = duty_slot(req.addr);
		ss     = stat_slot(req.addr);
		nxt_st = st_ff;
		// step prescalers
		nxt_st.slow_tick = (st_ff.slow_cnt == SLOW_WRAP);
		nxt_st.slow_cnt  = nxt_st.slow_tick ? 13'h0000
			: 13'(st_ff.slow_cnt + 13'h0001);
		nxt_st.fast_tick = (st_ff.fast_cnt == FAST_WRAP);
		nxt_st.fast_cnt  = nxt_st.fast_tick ? 9'h000
			: 9'(st_ff.fast_cnt + 9'h001);
		nxt_st.pin_prev  = drv_pin;
		// register writes
		if (req.wr && !req.stat_space) begin
			if (req.addr == OFS_CMD)
				nxt_st.cmd = req.wdata;
			if (ds >= 0)
				nxt_st.duty[ds] = req.wdata[6:0];
		end
		for (int d = 0; d < 3; d++) begin
			case (pwm_source_mode[d])
				PWM_SLOW: tick = st_ff.slow_tick;
				PWM_FAST: tick = st_ff.fast_tick;
				PWM_EXT:  tick = drv_pin[d] & ~st_ff.pin_prev[d];
				default:  tick = 1'b0;
			endcase
			if (pwm_source_mode[d] == PWM_NONE)
				nxt_st.phase[d] = 7'h00;
			else if (tick)
				nxt_st.phase[d] = (st_ff.phase[d] == PHASE_LAST)
					? 7'h00 : 7'(st_ff.phase[d] + 7'h01);
			pwm_on = (pwm_source_mode[d] == PWM_NONE) ||
				(st_ff.phase[d] < duty_clip(st_ff.duty[d]));
			want = and_select[d] ? (drv_pin[d] & st_ff.cmd[d])
				: (drv_pin[d] | st_ff.cmd[d]);
			nxt_st.drive[d] = want & pwm_on;
			sbyte = RST_BYTE;
			sbyte[BIT_OPEN] = open_load_raw[d]
				& open_detect_sink_enable[d];
			sbyte[BIT_OVER] = overcurrent_raw[d];
			sbyte[BIT_SUMMARY] = sbyte[BIT_OPEN] | sbyte[BIT_OVER];
			nxt_st.status[d] = sbyte;
		end
		nxt_st.ind = {st_ff.cmd[7:3], st_ff.drive};
		nxt_st.any_fault = st_ff.status[0][BIT_SUMMARY]
			| st_ff.status[1][BIT_SUMMARY]
			| st_ff.status[2][BIT_SUMMARY];
		// register reads
		nxt_st.rvalid = req.rd;
		if (req.rd) begin
			nxt_st.rdata = RST_BYTE;
			if (req.stat_space) begin
				if (ss >= 0)
					nxt_st.rdata = st_ff.status[ss];
				else if (req.addr == OFS_STATE_IND)
					nxt_st.rdata = st_ff.ind;
			end else begin
				if (req.addr == OFS_CMD)
					nxt_st.rdata = st_ff.cmd;
				else if (ds >= 0)
					nxt_st.rdata = {1'b0, st_ff.duty[ds]};
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rdata        = st_ff.rdata;
	assign rvalid       = st_ff.rvalid;
	assign drive_out    = st_ff.drive;
	assign low_side_out = st_ff.cmd[7:3];
	assign any_fault    = st_ff.any_fault;

	// ********************************************************
	// checks
	// ********************************************************
	cmd_write_a: assert property (@(posedge clock) disable iff (rst)
		req.wr && !req.stat_space && req.addr == OFS_CMD
		|=> st_ff.cmd == $past(req.wdata))
		else $error("command write not stored");
	duty_store_a: assert property (@(posedge clock) disable iff (rst)
		req.wr && !req.stat_space && req.addr == OFS_SPKA_DUTY
		|=> st_ff.duty[DRV_SPKA] == $past(req.wdata[6:0]))
		else $error("spark a duty not stored");
	sat_full_a: assert property (@(posedge clock) disable iff (rst)
		pwm_source_mode[0] != PWM_NONE && st_ff.duty[0] > DUTY_FULL
		&& st_ff.cmd[0] && !and_select[0] |=> st_ff.drive[0])
		else $error("saturated duty not full on");
	zero_duty_a: assert property (@(posedge clock) disable iff (rst)
		pwm_source_mode[0] != PWM_NONE && st_ff.duty[0] == 7'h00
		|=> !st_ff.drive[0])
		else $error("zero duty drove output");
	and_gate_a: assert property (@(posedge clock) disable iff (rst)
		pwm_source_mode[2] == PWM_NONE && and_select[2] && !drv_pin[2]
		|=> !st_ff.drive[2])
		else $error("and combine failed");
	summary_or_a: assert property (@(posedge clock) disable iff (rst)
		st_ff.status[1][BIT_SUMMARY] ==
		(st_ff.status[1][BIT_OPEN] | st_ff.status[1][BIT_OVER]))
		else $error("summary bit not or of flags");
	sink_off_a: assert property (@(posedge clock) disable iff (rst)
		!open_detect_sink_enable[0] |=> !st_ff.status[0][BIT_OPEN])
		else $error("open flag set with sink off");
	over_flag_a: assert property (@(posedge clock) disable iff (rst)
		overcurrent_raw[2] |=> st_ff.status[2][BIT_OVER])
		else $error("overcurrent not flagged");
	ind_track_a: assert property (@(posedge clock) disable iff (rst)
		##1 st_ff.ind == {$past(st_ff.cmd[7:3]), $past(st_ff.drive)})
		else $error("indicator mismatch");
	any_fault_a: assert property (@(posedge clock) disable iff (rst)
		st_ff.status[2][BIT_SUMMARY] |=> st_ff.any_fault)
		else $error("global fault missed");
	cmd_hold_a: assert property (@(posedge clock)
		disable iff (rst) !(req.wr && !req.stat_space)
		|=> st_ff.cmd == $past(st_ff.cmd))
		else $error("command changed without write");
	cmd_read_a: assert property (@(posedge clock)
		disable iff (rst) req.rd && !req.stat_space && req.addr == OFS_CMD
		|=> st_ff.rdata == $past(st_ff.cmd))
		else $error("command read wrong");
	spark_on_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[2] == PWM_NONE
		&& !and_select[2] && st_ff.cmd[2] |=> st_ff.drive[2])
		else $error("spark a not on with command set");
	heater_off_a: assert property (@(posedge clock)
		disable iff (rst) !drv_pin[0] && !st_ff.cmd[0]
		|=> !st_ff.drive[0])
		else $error("heater on with command clear");
	duty_spkb_a: assert property (@(posedge clock)
		disable iff (rst) req.wr && !req.stat_space
		&& req.addr == OFS_SPKB_DUTY
		|=> st_ff.duty[DRV_SPKB] == $past(req.wdata[6:0]))
		else $error("spark b duty not stored");
	duty_read_a: assert property (@(posedge clock)
		disable iff (rst) req.rd && !req.stat_space
		&& req.addr == OFS_HEAT_DUTY
		|=> st_ff.rdata == {1'b0, $past(st_ff.duty[DRV_HEAT])})
		else $error("duty read wrong");
	stat_nowr_a: assert property (@(posedge clock)
		disable iff (rst) req.wr && req.stat_space
		|=> st_ff.duty == $past(st_ff.duty)
		&& st_ff.cmd == $past(st_ff.cmd))
		else $error("status space write took effect");
	phase_range_a: assert property (@(posedge clock)
		disable iff (rst) st_ff.phase[0] <= PHASE_LAST
		&& st_ff.phase[1] <= PHASE_LAST
		&& st_ff.phase[2] <= PHASE_LAST)
		else $error("phase out of range");
	pwm_gate_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[0] != PWM_NONE
		&& st_ff.phase[0] >= st_ff.duty[0] |=> !st_ff.drive[0])
		else $error("drive on past duty point");
	phase_none_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[0] == PWM_NONE
		|=> st_ff.phase[0] == 7'h00)
		else $error("phase ran with no pwm source");
	phase_hold_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[0] == PWM_SLOW
		&& !st_ff.slow_tick |=> st_ff.phase[0] == $past(st_ff.phase[0]))
		else $error("phase moved without step");
	slow_step_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[0] == PWM_SLOW
		&& st_ff.slow_tick |=> st_ff.phase[0] != $past(st_ff.phase[0]))
		else $error("phase missed slow step");
	ext_step_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[0] == PWM_EXT
		&& drv_pin[0] && !st_ff.pin_prev[0]
		|=> st_ff.phase[0] != $past(st_ff.phase[0]))
		else $error("phase missed pin edge");
	fast_wrap_a: assert property (@(posedge clock)
		disable iff (rst) st_ff.fast_cnt == FAST_WRAP
		|=> st_ff.fast_tick && st_ff.fast_cnt == 9'h000)
		else $error("fast prescaler wrap wrong");
	slow_wrap_a: assert property (@(posedge clock)
		disable iff (rst) st_ff.slow_cnt == SLOW_WRAP
		|=> st_ff.slow_tick && st_ff.slow_cnt == 13'h0000)
		else $error("slow prescaler wrap wrong");
	tick_once_a: assert property (@(posedge clock)
		disable iff (rst) st_ff.fast_tick
		|=> !st_ff.fast_tick)
		else $error("fast step tick longer than one cycle");
	summary_all_a: assert property (@(posedge clock)
		disable iff (rst) st_ff.status[0][BIT_SUMMARY] ==
		(st_ff.status[0][BIT_OPEN] | st_ff.status[0][BIT_OVER])
		&& st_ff.status[2][BIT_SUMMARY] ==
		(st_ff.status[2][BIT_OPEN] | st_ff.status[2][BIT_OVER]))
		else $error("summary bit not or of flags");
	open_flag_a: assert property (@(posedge clock)
		disable iff (rst) open_load_raw[1] && open_detect_sink_enable[1]
		|=> st_ff.status[1][BIT_OPEN])
		else $error("open load not flagged");
	over_clear_a: assert property (@(posedge clock)
		disable iff (rst) !overcurrent_raw[0]
		|=> !st_ff.status[0][BIT_OVER])
		else $error("overcurrent flag without fault");
	fault_read_a: assert property (@(posedge clock)
		disable iff (rst) req.rd && req.stat_space
		&& req.addr == OFS_SPKA_FAULT
		|=> st_ff.rdata == $past(st_ff.status[DRV_SPKA]))
		else $error("fault read wrong");
	ind_read_a: assert property (@(posedge clock)
		disable iff (rst) req.rd && req.stat_space
		&& req.addr == OFS_STATE_IND
		|=> st_ff.rdata == $past(st_ff.ind))
		else $error("indicator read wrong");
	or_gate_a: assert property (@(posedge clock)
		disable iff (rst) pwm_source_mode[1] == PWM_NONE
		&& !and_select[1] && drv_pin[1] |=> st_ff.drive[1])
		else $error("or combine failed");
	any_clear_a: assert property (@(posedge clock)
		disable iff (rst) !st_ff.status[0][BIT_SUMMARY]
		&& !st_ff.status[1][BIT_SUMMARY]
		&& !st_ff.status[2][BIT_SUMMARY] |=> !st_ff.any_fault)
		else $error("global fault without driver fault");
	unused_zero_a: assert property (@(posedge clock)
		disable iff (rst) ((st_ff.status[0] | st_ff.status[1]
		| st_ff.status[2]) & 8'h73) == 8'h00)
		else $error("unused status bit set");
	unmapped_rd_a: assert property (@(posedge clock)
		disable iff (rst) req.rd && !req.stat_space && req.addr == 4'h5
		|=> st_ff.rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// File: dv/pdc_host.sv
// host model issuing register requests to the block
`timescale 1ns/1ns
`default_nettype none
module pdc_host (
	input  wire logic            clock,
	output var pdc_pkg::pdc_req_t req
);
	import pdc_pkg::*;
	initial req = '0;
	// one request, held across one rising edge
	task automatic put(input logic w, input logic s,
		input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		req = '{wr: w, rd: ~w, stat_space: s, addr: a, wdata: d};
		@(negedge clock);
		req.wr = 1'b0;
		req.rd = 1'b0;
		req.stat_space = ~s;
		req.addr = ~a;
		req.wdata = ~d;
	endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the pre-driver register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pdc_pkg::*;
	localparam int SS = 20;
	logic            clock = 1'b0;
	logic            rst = 1'b1;
	pdc_req_t        req;
	logic [2:0]      pin = '0, asel = '0, sink = '0, ol = '0, oc = '0;
	logic [2:0][1:0] mode = '0;
	logic [7:0]      rdata, c;
	logic            rvalid, any_fault;
	logic [2:0]      drive, g;
	logic [4:0]      low;
	logic [1:0]      f;
	logic [7:0]      exp_q[$];
	logic [31:0]     seed = 32'h00017D25, r;
	int              err_count = 0, n_tests = 0, cyc = 0, hi, j;
	initial begin
		forever #10 clock = ~clock;
	end
	pdc_host host (.clock(clock), .req(req));
	pdc_regs #(.SLOW_STEP(SS)) uut (.clock(clock), .rst(rst), .req(req),
		.drv_pin(pin), .and_select(asel), .open_detect_sink_enable(sink),
		.pwm_source_mode(mode), .open_load_raw(ol), .overcurrent_raw(oc),
		.rdata(rdata), .rvalid(rvalid), .drive_out(drive),
		.low_side_out(low), .any_fault(any_fault));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] x);
		n_tests++;
		if (got !== x) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, x);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic s, input logic [3:0] a,
		input logic [7:0] d);
		host.put(1'b1, s, a, d);
	endtask
	task automatic rd(input logic s, input logic [3:0] a,
		input logic [7:0] x);
		exp_q.push_back(x);
		host.put(1'b0, s, a, 8'h00);
	endtask
	// count heater on-cycles over one window
	task automatic pwm(input logic [1:0] m, input int d, input int n,
		input int x);
		mode[0] = m;
		wr(1'b0, OFS_HEAT_DUTY, d[7:0]);
		hi = 0;
		for (int k = 0; k < n + 5; k++) begin
			@(negedge clock);
			if (m == 2'b11)
				pin[0] = ~pin[0];
			if (k >= 5)
				hi += int'(drive[0] === 1'b1);
		end
		chk(16'(hi), 16'(x));
	endtask
	// ****************************************
	// read watcher and timeout
	// ****************************************
	always @(negedge clock) begin
		cyc++;
		if (cyc == 70000) begin
			err_count++;
			close_out();
		end else if (rvalid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(16'h0001, 16'h0000);
			else
				chk(16'(rdata), 16'(exp_q.pop_front()));
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (16) @(negedge clock);
		rst = 1'b0;
		rd(1'b0, OFS_CMD, 8'h00);
		rd(1'b0, OFS_HEAT_DUTY, 8'h00);
		rd(1'b1, OFS_SPKB_FAULT, 8'h00);
		rd(1'b1, OFS_STATE_IND, 8'h00);
		rd(1'b0, 4'h5, 8'h00);
		wr(1'b1, OFS_STATE_IND, 8'hFF);
		rd(1'b1, OFS_STATE_IND, 8'h00);
		for (int i = 0; i < 3; i++) begin
			c = 8'(xs());
			wr(1'b0, 4'(OFS_HEAT_DUTY + i), c | 8'h80);
			rd(1'b0, 4'(OFS_HEAT_DUTY + i), c & 8'h7F);
		end
		for (int k = 0; k < 8; k++) begin
			r = xs();
			{sink, ol, oc} = r[8:0];
			repeat (4) @(negedge clock);
			for (int d = 0; d < 3; d++) begin
				j = (d == 0) ? 0 : 3 - d;
				f = {sink[j] & ol[j], oc[j]};
				c = {|f, 3'h0, f, 2'h0};
				rd(1'b1, 4'(OFS_HEAT_FAULT + d), c);
			end
			chk(16'(any_fault), 16'(|(sink & ol | oc)));
		end
		for (int k = 0; k < 6; k++) begin
			c = 8'(xs());
			r = xs();
			pin = r[2:0];
			asel = r[5:3];
			wr(1'b0, OFS_CMD, c);
			repeat (4) @(negedge clock);
			g = asel & pin & c[2:0] | ~asel & (pin | c[2:0]);
			rd(1'b0, OFS_CMD, c);
			rd(1'b1, OFS_STATE_IND, {c[7:3], g});
			chk(16'(drive), 16'(g));
			chk(16'(low), 16'(c[7:3]));
		end
		pin = '0;
		asel = '0;
		wr(1'b0, OFS_CMD, 8'h01);
		pwm(2'b01, 50, 100 * SS, 50 * SS);
		pwm(2'b01, 100, 100 * SS, 100 * SS);
		pwm(2'b01, 127, 100 * SS, 100 * SS);
		pwm(2'b10, 1, 100 * FAST_STEP_CYC, FAST_STEP_CYC);
		pwm(2'b10, 0, 1000, 0);
		pwm(2'b11, 30, 200, 60);
		pwm(2'b00, 0, 100, 100);
		repeat (4) @(negedge clock);
		close_out();
	end
endmodule
`default_nettype wire
